// ---- pkg/rcad_map.svh ----
// Constants of the 8-bit execution core: offsets, fields, resets, timing
// ============================================================
// Behaviour
// - Twelve-bit instruction word, one fetched per cycle
// - Program fetch and data access on separate buses
// - Fetch next instruction while current one executes
// - Non-branch instructions finish in one instruction cycle
// - Program counter sized for 384 to 2K words
// - Special registers, PC included, live in file space
// - Direct and indirect file addressing for every operation
// - Eight-bit ALU: add, subtract, shift, logic
// - Arithmetic operands are two's complement
// - Two-operand: working register with file or literal
// - Single-operand: working register or file register
// - Working register eight bits, not addressable
// - ALU updates carry, nibble carry, zero flags
// - Subtraction carries act as borrow indicators
// - Oscillator mode drives quarter-rate cycle clock out
// - Master clear low resets the device; the APB slave and its control register reset only on RST
// - Data path eight bits, apart from instruction width
`ifndef RCAD_MAP_SVH
`define RCAD_MAP_SVH

// ============================================================
// Widths and timing
`define RCAD_INSTR_BITS 12
`define RCAD_DATA_BITS 8
`define RCAD_REF_INSTR_NS 200
`define RCAD_REF_OSC_MHZ 20
`define RCAD_INSTR_CLOCKS ((`RCAD_REF_INSTR_NS * `RCAD_REF_OSC_MHZ) / 1000)
`define RCAD_NOP_WORD 12'h000

// ============================================================
// File register map
`define RCAD_FA_INDIRECT 5'h00
`define RCAD_FA_PCL 5'h02
`define RCAD_FA_STATUS 5'h03
`define RCAD_FA_FSR 5'h04
`define RCAD_ST_CARRY 0
`define RCAD_ST_NIBBLE 1
`define RCAD_ST_ZERO 2
`define RCAD_ST_PAGE_LO 5
`define RCAD_ST_PAGE_HI 6
`define RCAD_ST_RESET 8'h18
`define RCAD_ST_WR_MASK 8'he7

// ============================================================
// APB register map
`define RCAD_APB_CTRL 12'h000
`define RCAD_APB_CORE 12'h004
`define RCAD_APB_PC 12'h008
`define RCAD_CTRL_RUN 0
`define RCAD_CTRL_OSC_MODE 1
`define RCAD_CTRL_RESET 2'h1

`endif

// ---- pkg/rcad_pkg.sv ----
// Types shared by the execution core and its ALU
package rcad_pkg;

  // ============================================================
  // ALU operations
  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_INC, ALU_DEC,
    ALU_RRF, ALU_RLF, ALU_SWAP, ALU_PASS_A, ALU_PASS_B, ALU_CLR, ALU_BCLR, ALU_BSET
  } rcad_alu_op_type;

  // ============================================================
  // ALU flags and result
  typedef struct packed {
    logic carry;
    logic nibble_carry_flag;
    logic zero;
  } rcad_flags_type;

  typedef struct packed {
    logic [7:0] result;
    rcad_flags_type flags;
  } rcad_alu_out_type;

endpackage : rcad_pkg

// ---- design/rcad_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rcad_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  generate
    if (WIDTH < 1)
    begin : g_check
      $error("rcad_sync width must be at least 1");
    end
  endgenerate

  // ============================================================
  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1 <= '0;
      dout <= '0;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : rcad_sync

// ---- design/rcad_alu.sv ----
// Eight-bit two's complement ALU with carry, nibble carry and zero
`timescale 1ns/1ps
module rcad_alu
  import rcad_pkg::*;
(
  input rcad_alu_op_type op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic [2:0] bit_sel,
  output rcad_alu_out_type out
);
  logic [8:0] wide;
  logic [4:0] low;
  logic [7:0] res;
  logic cy;
  logic ny;

  // ============================================================
  // Operation select
  always_comb
  begin
    wide = 9'h000;
    low = 5'h00;
    res = 8'h00;
    cy = 1'b0;
    ny = 1'b0;
    case (op)
      ALU_ADD:
      begin
        wide = {1'b0, a} + {1'b0, b};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        res = wide[7:0];
        cy = wide[8];
        ny = low[4];
      end
      ALU_SUB:
      begin
        wide = {1'b0, b} - {1'b0, a};
        low = {1'b0, b[3:0]} - {1'b0, a[3:0]};
        res = wide[7:0];
        cy = ~wide[8];                                      // High means no borrow
        ny = ~low[4];
      end
      ALU_AND: res = a & b;
      ALU_IOR: res = a | b;
      ALU_XOR: res = a ^ b;
      ALU_COM: res = ~b;
      ALU_INC: res = b + 8'h01;
      ALU_DEC: res = b - 8'h01;
      ALU_RRF:
      begin
        res = {cin, b[7:1]};
        cy = b[0];
      end
      ALU_RLF:
      begin
        res = {b[6:0], cin};
        cy = b[7];
      end
      ALU_SWAP: res = {b[3:0], b[7:4]};
      ALU_PASS_A: res = a;
      ALU_PASS_B: res = b;
      ALU_CLR: res = 8'h00;
      ALU_BCLR: res = b & ~(8'h01 << bit_sel);
      ALU_BSET: res = b | (8'h01 << bit_sel);
      default: res = 8'h00;
    endcase
  end

  // Result with flags; zero flag tests all eight bits
  assign out.result = res;
  assign out.flags.carry = cy;
  assign out.flags.nibble_carry_flag = ny;
  assign out.flags.zero = (res == 8'h00);
endmodule : rcad_alu

// ---- design/rcad_core.sv ----
// Execution core: two-stage pipeline, file registers, ALU and APB slave
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "rcad_map.svh"
module rcad_core
  import rcad_pkg::*;
#(
  parameter int PROG_WORDS = 512,
  parameter int FILE_DEPTH = 32,
  localparam int PC_WIDTH = $clog2(PROG_WORDS)
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic MASTER_CLEAR_N,
  output logic [PC_WIDTH-1:0] PROG_ADDR,
  input wire logic [`RCAD_INSTR_BITS-1:0] PROG_DATA,
  output logic CYCLE_RATE_OUTPUT,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  // ============================================================
  // Elaboration checks
  generate
    if (PROG_WORDS != 384 && PROG_WORDS != 512 && PROG_WORDS != 1024 && PROG_WORDS != 2048)
    begin : g_prog_check
      $error("rcad_core program size must be 384, 512, 1024 or 2048 words");
    end
    if (FILE_DEPTH < 8 || FILE_DEPTH > 32)
    begin : g_file_check
      $error("rcad_core file depth must lie between 8 and 32");
    end
  endgenerate

  // ============================================================
  // Declarations
  logic master_clear_n_sync, core_rst, cyc_en;
  logic [1:0] phase, next_phase;
  logic cycle_rate, next_cycle_rate;
  logic [1:0] ctrl, next_ctrl;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [PC_WIDTH-1:0] pc, next_pc;
  logic [PC_WIDTH-1:0] stack0, next_stack0;
  logic [PC_WIDTH-1:0] stack1, next_stack1;
  logic [`RCAD_INSTR_BITS-1:0] ir, next_ir;
  logic [7:0] w, next_w;
  logic [7:0] status, next_status;
  logic [7:0] fsr, next_fsr;
  logic [7:0] file [FILE_DEPTH];
  logic [7:0] next_file [FILE_DEPTH];
  logic [4:0] ea;
  logic [7:0] fval;
  logic [3:0] alu_code;
  rcad_alu_op_type alu_op;
  rcad_alu_out_type alu_out;
  logic use_lit, wr_w, wr_f, upd_c, upd_nc, upd_z;
  logic skip_zero, skip_clr, skip_set, do_goto, do_call, do_ret;
  logic [10:0] page_base;

  // ============================================================
  // Master clear pin synchroniser
  rcad_sync #(
    .WIDTH(1)
  ) u_master_clear_n_sync (
    .clk(CLK),
    .rst(RST),
    .din(MASTER_CLEAR_N),
    .dout(master_clear_n_sync)
  );
  assign core_rst = RST | ~master_clear_n_sync;

  // ============================================================
  // Instruction-cycle divider and cycle rate pin
  assign cyc_en = (phase == 2'(`RCAD_INSTR_CLOCKS - 1));
  // Pin only rises at a half-cycle boundary, so a mode change leaves no runt pulse
  always_comb
  begin
    next_phase = cyc_en ? 2'h0 : phase + 2'h1;
    next_cycle_rate = next_phase[1]
                      & (cycle_rate | (ctrl[`RCAD_CTRL_OSC_MODE] & ~next_phase[0]));
  end
  always_ff @(posedge CLK)
  begin
    if (core_rst)
    begin
      phase <= 2'h0;
      cycle_rate <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      cycle_rate <= next_cycle_rate;
    end
  end
  assign CYCLE_RATE_OUTPUT = cycle_rate;

  // ============================================================
  // Operand fetch over the data bus, direct or through FSR
  always_comb
  begin
    ea = (ir[4:0] == `RCAD_FA_INDIRECT) ? fsr[4:0] : ir[4:0];
    if (ea == `RCAD_FA_INDIRECT)
      fval = 8'h00;
    else if (ea == `RCAD_FA_PCL)
      fval = pc[7:0];
    else if (ea == `RCAD_FA_STATUS)
      fval = status;
    else if (ea == `RCAD_FA_FSR)
      fval = fsr;
    else if (32'(ea) < FILE_DEPTH)
      fval = file[ea];
    else
      fval = 8'h00;
  end

  // ============================================================
  // Instruction decode; the operation is gathered as a plain code, then typed once
  always_comb
  begin
    alu_code = ALU_PASS_B;
    use_lit = 1'b0;
    wr_w = 1'b0;
    wr_f = 1'b0;
    upd_c = 1'b0;
    upd_nc = 1'b0;
    upd_z = 1'b0;
    skip_zero = 1'b0;
    skip_clr = 1'b0;
    skip_set = 1'b0;
    do_goto = 1'b0;
    do_call = 1'b0;
    do_ret = 1'b0;
    casez (ir)
      12'b0000_001?_????: {alu_code, wr_f} = {ALU_PASS_A, 1'b1};
      12'b0000_0100_0000: {alu_code, wr_w, upd_z} = {ALU_CLR, 2'h3};
      12'b0000_011?_????: {alu_code, wr_f, upd_z} = {ALU_CLR, 2'h3};
      12'b0000_1???_????, 12'b0001_????_????, 12'b0010_????_????, 12'b0011_????_????:
      begin
        wr_w = ~ir[5];
        wr_f = ir[5];
        case (ir[9:6])
          4'h2: {alu_code, upd_c, upd_nc, upd_z} = {ALU_SUB, 3'h7};
          4'h3: {alu_code, upd_z} = {ALU_DEC, 1'b1};
          4'h4: {alu_code, upd_z} = {ALU_IOR, 1'b1};
          4'h5: {alu_code, upd_z} = {ALU_AND, 1'b1};
          4'h6: {alu_code, upd_z} = {ALU_XOR, 1'b1};
          4'h7: {alu_code, upd_c, upd_nc, upd_z} = {ALU_ADD, 3'h7};
          4'h8: {alu_code, upd_z} = {ALU_PASS_B, 1'b1};
          4'h9: {alu_code, upd_z} = {ALU_COM, 1'b1};
          4'ha: {alu_code, upd_z} = {ALU_INC, 1'b1};
          4'hb: {alu_code, skip_zero} = {ALU_DEC, 1'b1};
          4'hc: {alu_code, upd_c} = {ALU_RRF, 1'b1};
          4'hd: {alu_code, upd_c} = {ALU_RLF, 1'b1};
          4'he: alu_code = ALU_SWAP;
          default: {alu_code, skip_zero} = {ALU_INC, 1'b1};
        endcase
      end
      12'b0100_????_????: {alu_code, wr_f} = {ALU_BCLR, 1'b1};
      12'b0101_????_????: {alu_code, wr_f} = {ALU_BSET, 1'b1};
      12'b0110_????_????: skip_clr = 1'b1;
      12'b0111_????_????: skip_set = 1'b1;
      12'b1000_????_????: {alu_code, use_lit, wr_w, do_ret} = {ALU_PASS_B, 3'h7};
      12'b1001_????_????: do_call = 1'b1;
      12'b101?_????_????: do_goto = 1'b1;
      12'b1100_????_????: {alu_code, use_lit, wr_w} = {ALU_PASS_B, 2'h3};
      12'b1101_????_????: {alu_code, use_lit, wr_w, upd_z} = {ALU_IOR, 3'h7};
      12'b1110_????_????: {alu_code, use_lit, wr_w, upd_z} = {ALU_AND, 3'h7};
      12'b1111_????_????: {alu_code, use_lit, wr_w, upd_z} = {ALU_XOR, 3'h7};
      default: alu_code = ALU_PASS_B;
    endcase
    alu_op = rcad_alu_op_type'(alu_code);
  end

  // ============================================================
  // Arithmetic unit
  rcad_alu u_alu (
    .op(alu_op),
    .a(w),
    .b(use_lit ? ir[7:0] : fval),
    .cin(status[`RCAD_ST_CARRY]),
    .bit_sel(ir[7:5]),
    .out(alu_out)
  );

  assign page_base = {status[`RCAD_ST_PAGE_HI:`RCAD_ST_PAGE_LO], 9'h000};

  // ============================================================
  // Pipeline and execute: next state
  always_comb
  begin
    next_pc = pc;
    next_ir = ir;
    next_w = w;
    next_status = status;
    next_fsr = fsr;
    next_stack0 = stack0;
    next_stack1 = stack1;
    next_file = file;
    if (cyc_en && ctrl[`RCAD_CTRL_RUN])
    begin
      next_ir = PROG_DATA;                                  // Fetch while executing ir
      next_pc = pc + PC_WIDTH'(1);
      if (wr_w)
        next_w = alu_out.result;
      if (wr_f)
      begin
        if (ea == `RCAD_FA_PCL)
        begin
          next_pc = PC_WIDTH'(page_base | {3'h0, alu_out.result});
          next_ir = `RCAD_NOP_WORD;
        end
        else if (ea == `RCAD_FA_STATUS)
          next_status = (alu_out.result & `RCAD_ST_WR_MASK) | (status & ~`RCAD_ST_WR_MASK);
        else if (ea == `RCAD_FA_FSR)
          next_fsr = alu_out.result;
        else if (ea != `RCAD_FA_INDIRECT && 32'(ea) < FILE_DEPTH)
          next_file[ea] = alu_out.result;
      end
      // Flags win over a direct status write in the same cycle
      if (upd_c)
        next_status[`RCAD_ST_CARRY] = alu_out.flags.carry;
      if (upd_nc)
        next_status[`RCAD_ST_NIBBLE] = alu_out.flags.nibble_carry_flag;
      if (upd_z)
        next_status[`RCAD_ST_ZERO] = alu_out.flags.zero;
      // Skips drop the prefetched word
      if ((skip_zero && alu_out.flags.zero) || (skip_clr && !fval[ir[7:5]])
          || (skip_set && fval[ir[7:5]]))
        next_ir = `RCAD_NOP_WORD;
      if (do_goto)
      begin
        next_pc = PC_WIDTH'(page_base | {2'h0, ir[8:0]});
        next_ir = `RCAD_NOP_WORD;
      end
      if (do_call)
      begin
        next_stack1 = stack0;
        next_stack0 = pc;
        next_pc = PC_WIDTH'(page_base | {3'h0, ir[7:0]});
        next_ir = `RCAD_NOP_WORD;
      end
      if (do_ret)
      begin
        next_pc = stack0;
        next_stack0 = stack1;
        next_ir = `RCAD_NOP_WORD;
      end
    end
  end

  // Pipeline and execute: registers
  always_ff @(posedge CLK)
  begin
    if (core_rst)
    begin
      pc <= PC_WIDTH'(PROG_WORDS - 1);
      ir <= `RCAD_NOP_WORD;
      w <= 8'h00;
      status <= `RCAD_ST_RESET;
      fsr <= 8'h00;
      stack0 <= '0;
      stack1 <= '0;
      for (int i = 0; i < FILE_DEPTH; i++)
        file[i] <= 8'h00;
    end
    else
    begin
      pc <= next_pc;
      ir <= next_ir;
      w <= next_w;
      status <= next_status;
      fsr <= next_fsr;
      stack0 <= next_stack0;
      stack1 <= next_stack1;
      file <= next_file;
    end
  end

  assign PROG_ADDR = pc;

  // ============================================================
  // APB slave: next state
  always_comb
  begin
    next_ctrl = ctrl;
    next_prdata = PRDATA;
    next_pslverr = PSLVERR;
    next_pready = PSEL & PENABLE & ~PREADY;
    if (PSEL && PENABLE && !PREADY)
    begin
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (PADDR == `RCAD_APB_CTRL)
        next_prdata = {30'h0, ctrl};
      else if (PADDR == `RCAD_APB_CORE)
        next_prdata = {16'h0000, status, w};
      else if (PADDR == `RCAD_APB_PC)
        next_prdata = {21'h0, 11'(pc)};
      else
        next_pslverr = 1'b1;
    end
    if (PSEL && PENABLE && PREADY && PWRITE && PADDR == `RCAD_APB_CTRL)
      next_ctrl = PWDATA[1:0];
  end

  // APB slave: registers
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctrl <= `RCAD_CTRL_RESET;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end
endmodule : rcad_core

// ---- verif/rcad_core_asserts.sv ----
// Concurrent checks on the execution core ports
`timescale 1ns/1ps
module rcad_core_asserts
  import rcad_pkg::*;
#(
  parameter int PROG_WORDS = 512,
  localparam int PC_WIDTH = $clog2(PROG_WORDS)
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic MASTER_CLEAR_N,
  input wire logic [PC_WIDTH-1:0] PROG_ADDR,
  input wire logic CYCLE_RATE_OUTPUT,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  // ============================================================
  // Address decode helper
  logic mapped;
  assign mapped = (PADDR == 12'h000) || (PADDR == 12'h004) || (PADDR == 12'h008);

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // ============================================================
  // Checks
  a_reset_state: assert property (disable iff (1'b0) RST |=>
    PROG_ADDR == PC_WIDTH'(PROG_WORDS - 1) && !PREADY && !PSLVERR && PRDATA == 32'h0)
    else $error("reset state of outputs wrong");
  a_ready_timing: assert property ((PSEL && PENABLE && !PREADY) |=> PREADY)
    else $error("ready late");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE))
    else $error("ready without access");
  a_idle_quiet: assert property (!PSEL |=> !PREADY)
    else $error("ready while idle");
  a_unmapped_err: assert property (PREADY && !mapped |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (PREADY && mapped |-> !PSLVERR)
    else $error("mapped access refused");
  a_fetch_stands: assert property (disable iff (RST || !MASTER_CLEAR_N)
    $changed(PROG_ADDR) |=> $stable(PROG_ADDR) [*3])
    else $error("program address held under four clocks");
  a_osc_period: assert property (disable iff (RST || !MASTER_CLEAR_N)
    $rose(CYCLE_RATE_OUTPUT) |=> CYCLE_RATE_OUTPUT ##1 !CYCLE_RATE_OUTPUT [*2]
    ##1 CYCLE_RATE_OUTPUT)
    else $error("cycle clock out of shape");
endmodule : rcad_core_asserts

bind rcad_core rcad_core_asserts #(.PROG_WORDS(PROG_WORDS)) u_asserts (.CLK(CLK), .RST(RST),
  .MASTER_CLEAR_N(MASTER_CLEAR_N), .PROG_ADDR(PROG_ADDR), .CYCLE_RATE_OUTPUT(CYCLE_RATE_OUTPUT),
  .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR));

// ---- verif/rcad_prog_model.sv ----
// Program store model with settable read lag
`timescale 1ns/1ps
module rcad_prog_model #(
  parameter int AW = 9,
  parameter int LAG = 0
) (
  input wire logic clk,
  input wire logic [AW-1:0] addr,
  output logic [11:0] data
);
  logic [11:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] last;
  int age;

  // ============================================================
  // Age of the current address, reset on every change
  always_ff @(posedge clk)
  begin
    if (addr !== last)
      age <= 0;
    else if (age < LAG)
      age <= age + 1;
    last <= addr;
  end

  // Whole word once settled, inverted word while still settling
  assign data = (addr === last && age >= LAG) ? mem[addr] : ~mem[addr];
endmodule : rcad_prog_model

// ---- verif/tb.sv ----
// Self-checking bench for the execution core
`timescale 1ns/1ps
module tb;
  import rcad_pkg::*;
  logic clk, rst, master_clear_n, psel, penable, pwrite, pready, pslverr, cyc_out, prev, err;
  logic [8:0] prog_addr;
  logic [11:0] prog_data, paddr, second;
  logic [31:0] pwdata, prdata, rd, v;
  int failures, checks, n;

  rcad_core #(.PROG_WORDS(512)) DUT (.CLK(clk), .RST(rst), .MASTER_CLEAR_N(master_clear_n),
    .PROG_ADDR(prog_addr), .PROG_DATA(prog_data), .CYCLE_RATE_OUTPUT(cyc_out), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr));
  rcad_prog_model #(.AW(9), .LAG(2)) u_prog (.clk(clk), .addr(prog_addr), .data(prog_data));

  // ============================================================
  // Clock and watchdog
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end

  // ============================================================
  // Tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, held until ready is seen at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    t = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++t < 20);
    if (t >= 20)
      failures++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb

  // Load a short program, clear the core, time it and read W and status
  task run_case(input logic [11:0] op, input logic [7:0] a, input logic [7:0] b,
                input logic [15:0] exp);
    master_clear_n <= 0;
    repeat (6) @(posedge clk);
    u_prog.mem[0] = {4'hc, a};
    u_prog.mem[1] = second;
    u_prog.mem[2] = {4'hc, b};
    u_prog.mem[3] = op;
    u_prog.mem[4] = 12'ha04;
    u_prog.mem[5] = 12'hc77;
    master_clear_n <= 1;
    n = 0;
    while (prog_addr !== 9'h000 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (prog_addr !== 9'h005 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    chk(n, 24);
    repeat (12) @(posedge clk);
    apb(0, 12'h004, 0);
    chk(rd, {16'h0, exp});
  endtask : run_case

  task end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // ============================================================
  // Main sequence
  initial
  begin
    failures = 0;
    checks = 0;
    rst = 1;
    master_clear_n = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    second = 12'h030;
    for (int i = 0; i < 512; i++)
      u_prog.mem[i] = 12'h000;
    u_prog.mem[511] = 12'ha00;
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    apb(0, 12'h000, 0);
    chk(rd, 32'h1);
    apb(0, 12'h00c, 0);
    chk({err, rd[30:0]}, 32'h80000000);
    run_case(12'h1d0, 8'h0f, 8'h01, 16'h1a10);
    run_case(12'h1d0, 8'hff, 8'h01, 16'h1f00);
    run_case(12'h090, 8'h10, 8'h20, 16'h1af0);
    run_case(12'h090, 8'h35, 8'h35, 16'h1f00);
    run_case(12'h090, 8'h30, 8'h01, 16'h192f);
    run_case(12'h150, 8'hf0, 8'h3c, 16'h1830);
    run_case(12'h190, 8'h5a, 8'h5a, 16'h1c00);
    second = 12'h024;
    run_case(12'h1c0, 8'h04, 8'h05, 16'h1809);
    second = 12'h030;
    run_case(12'h202, 8'h00, 8'h00, 16'h1804);
    run_case(12'h310, 8'h03, 8'h77, 16'h1901);
    apb(1, 12'h004, 32'hffff);
    apb(0, 12'h004, 0);
    chk(rd, 32'h1901);
    apb(0, 12'h008, 0);
    chk(rd >> 1, 32'h2);
    apb(1, 12'h000, 0);
    v = {23'h0, prog_addr};
    repeat (20) @(posedge clk);
    chk({23'h0, prog_addr}, v);
    apb(1, 12'h000, 3);
    apb(0, 12'h000, 0);
    chk(rd, 32'h3);
    prev = cyc_out;
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      if (cyc_out === 1'b1 && prev === 1'b0)
        n++;
      prev = cyc_out;
    end
    chk(n, 10);
    end_sim();
  end
endmodule : tb
